// *** common/dmw_pkg.sv ***
// constants, field layouts and carrier types for the table walk control block
// assumes one 250 MHz clock shared by host port, dsp port and walker memory port
package dmw_pkg;
    localparam int VA_W = 24;
    localparam int TAG_W = 14;
    localparam int OFS_W = 10;
    localparam int PA_W = 32;
    localparam int PPAGE_W = 22;
    localparam int BASE_W = 25;
    localparam int BASE_LSB = 7;
    localparam int HALF_W = 16;

    localparam logic [31:0] ADDR_PRELOAD = 32'hfffed200;
    localparam logic [31:0] ADDR_WALK_ST = 32'hfffed204;
    localparam logic [31:0] ADDR_CONTROL = 32'hfffed208;
    localparam logic [31:0] ADDR_FAULT_H = 32'hfffed20c;
    localparam logic [31:0] ADDR_FAULT_L = 32'hfffed210;
    localparam logic [31:0] ADDR_CAUSE = 32'hfffed214;
    localparam logic [31:0] ADDR_ACK = 32'hfffed218;
    localparam logic [31:0] ADDR_TB_H = 32'hfffed21c;
    localparam logic [31:0] ADDR_TB_L = 32'hfffed220;
    localparam logic [31:0] ADDR_LOCK = 32'hfffed224;
    localparam logic [31:0] ADDR_ACCESS = 32'hfffed228;
    localparam logic [31:0] ADDR_TAG_H = 32'hfffed22c;
    localparam logic [31:0] ADDR_TAG_L = 32'hfffed230;
    localparam logic [31:0] ADDR_XL_H = 32'hfffed234;
    localparam logic [31:0] ADDR_XL_L = 32'hfffed238;
    localparam logic [31:0] ADDR_FLUSH_ALL = 32'hfffed23c;
    localparam logic [31:0] ADDR_FLUSH_ONE = 32'hfffed240;
    localparam logic [31:0] ADDR_RB_TAG_H = 32'hfffed244;
    localparam logic [31:0] ADDR_RB_TAG_L = 32'hfffed248;
    localparam logic [31:0] ADDR_RB_XL_H = 32'hfffed24c;
    localparam logic [31:0] ADDR_RB_XL_L = 32'hfffed250;
    localparam logic [31:0] ADDR_IDLE = 32'hfffed254;
    localparam logic [15:0] DSP_IO_PRELOAD = 16'h4400;

    localparam int WS_PENDING_BIT = 0;
    localparam int WS_ACTIVE_BIT = 1;
    localparam int CTL_RESET_BIT = 0;
    localparam int CTL_XLATE_BIT = 1;
    localparam int CTL_WALK_BIT = 2;
    localparam int CTL_W = 3;
    localparam int LOCK_VICT_LSB = 4;
    localparam int LOCK_BASE_LSB = 10;
    localparam int ACC_WRITE_BIT = 0;
    localparam int ACC_READ_BIT = 1;
    localparam int FLUSH_GO_BIT = 0;
    localparam int PERM_RD_BIT = 0;
    localparam int PERM_WR_BIT = 1;
    localparam int PERM_W = 2;
    localparam int XL_L_PPAGE_LSB = 10;
    localparam int PPAGE_LO_W = 6;
    localparam int IDLE_W = 2;
    localparam int CAUSE_W = 3;
    localparam logic [CAUSE_W-1:0] FC_MISS = 3'h1;
    localparam logic [CAUSE_W-1:0] FC_PERM = 3'h2;
    localparam logic [CAUSE_W-1:0] FC_TABLE = 3'h4;

    typedef struct packed {
        logic valid;
        logic [TAG_W-1:0] tag;
        logic [PPAGE_W-1:0] ppage;
        logic [PERM_W-1:0] perm;
    } dmw_entry_type;

    typedef struct packed {
        logic sel;
        logic we;
        logic [31:0] addr;
        logic [31:0] wdata;
    } dmw_host_req_type;

    typedef struct packed {
        logic req;
        logic write;
        logic [VA_W-1:0] vaddr;
    } dmw_lookup_type;
endpackage : dmw_pkg

// *** verilog/dmw_walk_ctrl.sv ***
// translation unit with tlb, hardware table walker, preload and host registers
// assumes host, dsp i/o and walker memory ports are logic on the same clock
module dmw_walk_ctrl #(
    parameter int ENTRIES = 8
) (
    input wire logic clk,
    input wire logic srst,
    input wire dmw_pkg::dmw_host_req_type host_req,
    output logic [31:0] host_rdata,
    input wire logic dsp_io_we,
    input wire logic [15:0] dsp_io_addr,
    input wire logic [31:0] dsp_io_wdata,
    input wire dmw_pkg::dmw_lookup_type lk,
    output logic lk_done,
    output logic [dmw_pkg::PA_W-1:0] lk_paddr,
    output logic wk_req,
    output logic [31:0] wk_addr,
    input wire logic wk_ack,
    input wire logic [31:0] wk_rdata,
    output logic fault_irq
);
    import dmw_pkg::*;

    localparam int PW = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;
    localparam logic [PW-1:0] LAST_IDX = PW'(ENTRIES - 1);
    localparam int PAD_W = PA_W - VA_W;

    typedef enum logic [1:0] {ST_IDLE, ST_WALK, ST_FAULT} dmw_state_type;

    function automatic logic is_wr(input dmw_host_req_type r, input logic [31:0] a);
        return r.sel && r.we && (r.addr == a);
    endfunction : is_wr

    dmw_state_type st_r, st_nxt;
    logic [CTL_W-1:0] ctrl_r;
    logic [BASE_W-1:0] tb_r;
    logic [PW-1:0] base_ptr_r;
    logic [PW-1:0] victim_r, victim_nxt;
    dmw_entry_type stage_r;
    dmw_entry_type rb_r;
    dmw_entry_type tlb_r [ENTRIES];
    logic [VA_W-1:0] fault_va_r;
    logic [CAUSE_W-1:0] fault_cause_r, cause_nxt;
    logic [IDLE_W-1:0] idle_r;
    logic [TAG_W-1:0] preload_tag_r;
    logic pending_r, pending_nxt;
    logic src_pre_r, src_pre_nxt;
    logic [TAG_W-1:0] wtag_r, wtag_nxt;
    logic lk_done_r, done_nxt;
    logic [PA_W-1:0] lk_paddr_r, paddr_nxt;
    logic wk_req_r;
    logic [31:0] wk_addr_r;
    logic fault_irq_r;
    logic [31:0] host_rdata_r, rd_mux;
    logic fault_set, fill_en, pre_done;
    logic [ENTRIES-1:0] hit_vec, valid_vec, keep_vec;
    logic hit_any;
    dmw_entry_type hit_ent;

    // soft reset: reset release bit low holds everything but control and host read data at default
    wire unit_rst = srst || !ctrl_r[CTL_RESET_BIT];
    wire xlate_on = ctrl_r[CTL_XLATE_BIT];
    wire walk_on = ctrl_r[CTL_WALK_BIT];
    wire host_rd = host_req.sel && !host_req.we;
    wire dsp_pre_wr = dsp_io_we && (dsp_io_addr == DSP_IO_PRELOAD) && !unit_rst;
    wire ack_wr = is_wr(host_req, ADDR_ACK) && !unit_rst;
    wire cfg_ok = !unit_rst && !walk_on;
    wire tb_h_wr = is_wr(host_req, ADDR_TB_H) && cfg_ok;
    wire tb_l_wr = is_wr(host_req, ADDR_TB_L) && cfg_ok;
    wire lock_wr = is_wr(host_req, ADDR_LOCK) && cfg_ok;
    wire acc_wr = is_wr(host_req, ADDR_ACCESS) && cfg_ok;
    wire man_wr = acc_wr && host_req.wdata[ACC_WRITE_BIT];
    wire man_rd = acc_wr && host_req.wdata[ACC_READ_BIT];
    wire stg_ok = !unit_rst;
    wire flush_all_wr = is_wr(host_req, ADDR_FLUSH_ALL) && stg_ok
        && host_req.wdata[FLUSH_GO_BIT];
    wire flush_one_wr = is_wr(host_req, ADDR_FLUSH_ONE) && stg_ok
        && host_req.wdata[FLUSH_GO_BIT];
    wire accept = lk.req && !lk_done_r;
    wire [TAG_W-1:0] lk_tag = lk.vaddr[VA_W-1 -: TAG_W];
    wire perm_ok = lk.write ? hit_ent.perm[PERM_WR_BIT] : hit_ent.perm[PERM_RD_BIT];
    wire [PERM_W-1:0] desc_perm = wk_rdata[PERM_W-1:0];
    wire [31:0] tb_addr = {tb_r, {BASE_LSB{1'b0}}};
    wire [31:0] walk_addr_nxt = tb_addr + {16'h0, wtag_nxt, 2'h0};
    wire [PW-1:0] victim_adv = (victim_r == LAST_IDX) ? base_ptr_r : victim_r + 1'b1;

    dmw_entry_type fill_ent;
    assign fill_ent.valid = 1'b1;
    assign fill_ent.tag = wtag_r;
    assign fill_ent.ppage = wk_rdata[31 -: PPAGE_W];
    assign fill_ent.perm = desc_perm;

    // per-entry storage, lookup compare and flush handling
    for (genvar i = 0; i < ENTRIES; i++) begin : g_ent
        assign hit_vec[i] = tlb_r[i].valid && (tlb_r[i].tag == lk_tag);
        assign valid_vec[i] = tlb_r[i].valid;
        assign keep_vec[i] = PW'(i) >= base_ptr_r;
        always_ff @(posedge clk) begin
            if (unit_rst) begin
                tlb_r[i] <= '0;
            end else if (fill_en && victim_r == PW'(i)) begin
                tlb_r[i] <= fill_ent;
            end else if (man_wr && victim_r == PW'(i)) begin
                tlb_r[i] <= stage_r;
            end else if (flush_all_wr && keep_vec[i]) begin
                tlb_r[i].valid <= 1'b0;
            end else if (flush_one_wr && victim_r == PW'(i)) begin
                tlb_r[i].valid <= 1'b0;
            end
        end
    end

    always_comb begin
        hit_any = 1'b0;
        hit_ent = '0;
        for (int i = 0; i < ENTRIES; i++) begin
            if (hit_vec[i]) begin
                hit_any = 1'b1;
                hit_ent = tlb_r[i];
            end
        end
    end

    // lookup and walker sequencing
    always_comb begin
        st_nxt = st_r;
        src_pre_nxt = src_pre_r;
        wtag_nxt = wtag_r;
        done_nxt = 1'b0;
        paddr_nxt = lk_paddr_r;
        fault_set = 1'b0;
        cause_nxt = fault_cause_r;
        fill_en = 1'b0;
        pre_done = 1'b0;
        case (st_r)
            ST_IDLE: begin
                if (pending_r && walk_on) begin
                    st_nxt = ST_WALK;
                    src_pre_nxt = 1'b1;
                    wtag_nxt = preload_tag_r;
                end else if (accept) begin
                    if (!xlate_on) begin
                        done_nxt = 1'b1;
                        paddr_nxt = {{PAD_W{1'b0}}, lk.vaddr};
                    end else if (hit_any && perm_ok) begin
                        done_nxt = 1'b1;
                        paddr_nxt = {hit_ent.ppage, lk.vaddr[OFS_W-1:0]};
                    end else if (hit_any) begin
                        fault_set = 1'b1;
                        cause_nxt = FC_PERM;
                    end else if (walk_on) begin
                        st_nxt = ST_WALK;
                        src_pre_nxt = 1'b0;
                        wtag_nxt = lk_tag;
                    end else begin
                        fault_set = 1'b1;
                        cause_nxt = FC_MISS;
                    end
                end
            end
            ST_WALK: begin
                if (wk_ack) begin
                    st_nxt = ST_IDLE;
                    pre_done = src_pre_r;
                    if (desc_perm != '0) begin
                        fill_en = 1'b1;
                    end else if (!src_pre_r) begin
                        fault_set = 1'b1;
                        cause_nxt = FC_TABLE;
                    end
                end
            end
            ST_FAULT: begin
                if (ack_wr) begin
                    st_nxt = ST_IDLE;
                end
            end
            default: begin
                st_nxt = ST_IDLE;
            end
        endcase
        if (fault_set) begin
            st_nxt = ST_FAULT;
        end
    end

    // a new preload write wins over completion of the previous one
    assign pending_nxt = dsp_pre_wr ? 1'b1 : (pre_done ? 1'b0 : pending_r);

    always_comb begin
        victim_nxt = victim_r;
        if (lock_wr) begin
            victim_nxt = host_req.wdata[LOCK_VICT_LSB +: PW];
        end else if (fill_en) begin
            victim_nxt = victim_adv;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_r <= '0;
        end else if (is_wr(host_req, ADDR_CONTROL)) begin
            ctrl_r <= host_req.wdata[CTL_RESET_BIT] ? host_req.wdata[CTL_W-1:0] : '0;
        end
    end

    always_ff @(posedge clk) begin
        if (unit_rst) begin
            st_r <= ST_IDLE;
            src_pre_r <= 1'b0;
            wtag_r <= '0;
            lk_done_r <= 1'b0;
            lk_paddr_r <= '0;
            wk_req_r <= 1'b0;
            wk_addr_r <= '0;
            fault_irq_r <= 1'b0;
            pending_r <= 1'b0;
            victim_r <= '0;
        end else begin
            st_r <= st_nxt;
            src_pre_r <= src_pre_nxt;
            wtag_r <= wtag_nxt;
            lk_done_r <= done_nxt;
            lk_paddr_r <= paddr_nxt;
            wk_req_r <= (st_nxt == ST_WALK);
            fault_irq_r <= (st_nxt == ST_FAULT);
            pending_r <= pending_nxt;
            victim_r <= victim_nxt;
            if (st_r != ST_WALK && st_nxt == ST_WALK) begin
                wk_addr_r <= walk_addr_nxt;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (unit_rst) begin
            fault_va_r <= '0;
            fault_cause_r <= '0;
            preload_tag_r <= '0;
        end else begin
            if (fault_set) begin
                fault_va_r <= lk.vaddr;
                fault_cause_r <= cause_nxt;
            end
            if (dsp_pre_wr) begin
                preload_tag_r <= dsp_io_wdata[TAG_W-1:0];
            end
        end
    end

    // host configuration and staging registers
    always_ff @(posedge clk) begin
        if (unit_rst) begin
            tb_r <= '0;
            base_ptr_r <= '0;
            stage_r <= '0;
            rb_r <= '0;
            idle_r <= '0;
        end else begin
            if (tb_h_wr) begin
                tb_r[BASE_W-1 -: HALF_W] <= host_req.wdata[HALF_W-1:0];
            end
            if (tb_l_wr) begin
                tb_r[BASE_W-HALF_W-1:0] <= host_req.wdata[HALF_W-1:BASE_LSB];
            end
            if (lock_wr) begin
                base_ptr_r <= host_req.wdata[LOCK_BASE_LSB +: PW];
            end
            if (is_wr(host_req, ADDR_TAG_H)) begin
                stage_r.tag <= host_req.wdata[TAG_W-1:0];
            end
            if (is_wr(host_req, ADDR_TAG_L)) begin
                stage_r.valid <= host_req.wdata[0];
            end
            if (is_wr(host_req, ADDR_XL_H)) begin
                stage_r.ppage[PPAGE_W-1 -: HALF_W] <= host_req.wdata[HALF_W-1:0];
            end
            if (is_wr(host_req, ADDR_XL_L)) begin
                stage_r.ppage[PPAGE_LO_W-1:0] <= host_req.wdata[XL_L_PPAGE_LSB +: PPAGE_LO_W];
                stage_r.perm <= host_req.wdata[PERM_W-1:0];
            end
            if (man_rd) begin
                rb_r <= tlb_r[victim_r];
            end
            if (is_wr(host_req, ADDR_IDLE)) begin
                idle_r <= host_req.wdata[IDLE_W-1:0];
            end
        end
    end

    // host read decode; unmapped and write-only locations read zero
    always_comb begin
        rd_mux = '0;
        if (host_req.addr == ADDR_PRELOAD) begin
            rd_mux[TAG_W-1:0] = preload_tag_r;
        end else if (host_req.addr == ADDR_WALK_ST) begin
            rd_mux[WS_PENDING_BIT] = pending_r;
            rd_mux[WS_ACTIVE_BIT] = (st_r == ST_WALK) && !src_pre_r;
        end else if (host_req.addr == ADDR_CONTROL) begin
            rd_mux[CTL_W-1:0] = ctrl_r;
        end else if (host_req.addr == ADDR_FAULT_H) begin
            rd_mux[VA_W-HALF_W-1:0] = fault_va_r[VA_W-1:HALF_W];
        end else if (host_req.addr == ADDR_FAULT_L) begin
            rd_mux[HALF_W-1:0] = fault_va_r[HALF_W-1:0];
        end else if (host_req.addr == ADDR_CAUSE) begin
            rd_mux[CAUSE_W-1:0] = fault_cause_r;
        end else if (host_req.addr == ADDR_TB_H) begin
            rd_mux[HALF_W-1:0] = tb_r[BASE_W-1 -: HALF_W];
        end else if (host_req.addr == ADDR_TB_L) begin
            rd_mux[HALF_W-1:BASE_LSB] = tb_r[BASE_W-HALF_W-1:0];
        end else if (host_req.addr == ADDR_LOCK) begin
            rd_mux[LOCK_BASE_LSB +: PW] = base_ptr_r;
            rd_mux[LOCK_VICT_LSB +: PW] = victim_r;
        end else if (host_req.addr == ADDR_TAG_H) begin
            rd_mux[TAG_W-1:0] = stage_r.tag;
        end else if (host_req.addr == ADDR_TAG_L) begin
            rd_mux[0] = stage_r.valid;
        end else if (host_req.addr == ADDR_XL_H) begin
            rd_mux[HALF_W-1:0] = stage_r.ppage[PPAGE_W-1 -: HALF_W];
        end else if (host_req.addr == ADDR_XL_L) begin
            rd_mux[XL_L_PPAGE_LSB +: PPAGE_LO_W] = stage_r.ppage[PPAGE_LO_W-1:0];
            rd_mux[PERM_W-1:0] = stage_r.perm;
        end else if (host_req.addr == ADDR_RB_TAG_H) begin
            rd_mux[TAG_W-1:0] = rb_r.tag;
        end else if (host_req.addr == ADDR_RB_TAG_L) begin
            rd_mux[0] = rb_r.valid;
        end else if (host_req.addr == ADDR_RB_XL_H) begin
            rd_mux[HALF_W-1:0] = rb_r.ppage[PPAGE_W-1 -: HALF_W];
        end else if (host_req.addr == ADDR_RB_XL_L) begin
            rd_mux[XL_L_PPAGE_LSB +: PPAGE_LO_W] = rb_r.ppage[PPAGE_LO_W-1:0];
            rd_mux[PERM_W-1:0] = rb_r.perm;
        end else if (host_req.addr == ADDR_IDLE) begin
            rd_mux[IDLE_W-1:0] = idle_r;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            host_rdata_r <= '0;
        end else if (host_rd) begin
            host_rdata_r <= rd_mux;
        end
    end

    assign host_rdata = host_rdata_r;
    assign lk_done = lk_done_r;
    assign lk_paddr = lk_paddr_r;
    assign wk_req = wk_req_r;
    assign wk_addr = wk_addr_r;
    assign fault_irq = fault_irq_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (unit_rst);

    a_preload_sets_bit: assert property (dsp_pre_wr |=> pending_r)
        else $error("preload write did not set pending");
    a_preload_clears: assert property ($fell(pending_r) |-> $past(wk_ack) && $past(src_pre_r))
        else $error("pending cleared without preload walk finishing");
    a_miss_starts_walk: assert property (
        st_r == ST_IDLE && accept && xlate_on && walk_on && !hit_any && !pending_r
        |=> wk_req && wk_addr == tb_addr + {16'h0, $past(lk_tag), 2'h0})
        else $error("miss did not start walk");
    a_preload_first: assert property (st_r == ST_IDLE && pending_r && walk_on |=> src_pre_r)
        else $error("miss walk overtook preload");
    a_lock_blocked: assert property (is_wr(host_req, ADDR_LOCK) && walk_on |=> $stable(base_ptr_r))
        else $error("lock write took effect with walker enabled");
    a_fault_holds: assert property (fault_irq && !ack_wr |=> fault_irq && !lk_done)
        else $error("fault released without acknowledge");
    a_fault_capture: assert property ($rose(fault_irq) |-> fault_va_r == $past(lk.vaddr)
        && fault_cause_r != '0)
        else $error("fault address or cause not captured");
    a_ack_resolves: assert property (fault_irq && ack_wr |=> !fault_irq)
        else $error("acknowledge did not clear fault");
    a_flush_all: assert property (flush_all_wr && !fill_en |=> (valid_vec & keep_vec) == '0)
        else $error("global flush left an unprotected entry valid");
    a_done_pulse: assert property (lk_done |=> !lk_done)
        else $error("lookup done held for more than one cycle");
endmodule : dmw_walk_ctrl

// *** verif/dmw_mem_model.sv ***
// walker memory model: one descriptor read at a time
// assumes the shared clock; bad forces an invalid descriptor
module dmw_mem_model (
    input wire logic clk,
    input wire logic srst,
    input wire logic wk_req,
    input wire logic [31:0] wk_addr,
    input wire logic slow,
    input wire logic bad,
    output logic wk_ack,
    output logic [31:0] wk_rdata
);
    logic [3:0] cnt_r;
    always_ff @(posedge clk) begin
        wk_ack <= 1'b0;
        cnt_r <= 4'h0;
        // idle bus keeps toggling
        wk_rdata <= srst ? 32'h0 : ~wk_rdata;
        if (!srst && wk_req && !wk_ack) begin
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == (slow ? 4'h5 : 4'h0)) begin
                wk_ack <= 1'b1;
                // descriptor from table address
                wk_rdata <= {wk_addr[23:2], 8'h0, bad ? 2'h0 : 2'h3};
            end
        end
    end
endmodule : dmw_mem_model

// *** verif/dmw_walk_ctrl_tb.sv ***
// self-checking bench for the table walk control block
// assumes the memory model on the walker port
module dmw_walk_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dmw_pkg::*;
    localparam logic [31:0] TB = 32'h00123480;
    logic clk, srst, dsp_io_we, lk_done, wk_req, wk_ack, fault_irq, slow, bad;
    logic [15:0] dsp_io_addr;
    logic [31:0] host_rdata, dsp_io_wdata, lk_paddr, wk_addr, wk_rdata, d;
    dmw_host_req_type host_req;
    dmw_lookup_type lk;
    int err_count, num_checks, vict, bptr, t;
    int mt[8], mp[8], mv[8];
    dmw_walk_ctrl #(.ENTRIES(8)) dmw_walk_ctrl_i (.clk(clk), .srst(srst),
        .host_req(host_req), .host_rdata(host_rdata), .dsp_io_we(dsp_io_we),
        .dsp_io_addr(dsp_io_addr), .dsp_io_wdata(dsp_io_wdata), .lk(lk),
        .lk_done(lk_done), .lk_paddr(lk_paddr), .wk_req(wk_req), .wk_addr(wk_addr),
        .wk_ack(wk_ack), .wk_rdata(wk_rdata), .fault_irq(fault_irq));
    dmw_mem_model dmw_mem_model_i (.clk(clk), .srst(srst), .wk_req(wk_req),
        .wk_addr(wk_addr), .slow(slow), .bad(bad), .wk_ack(wk_ack), .wk_rdata(wk_rdata));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic hw(input logic [31:0] a, input logic [31:0] v);
        @(posedge clk);
        host_req <= '{1'b1, 1'b1, a, v};
        @(posedge clk);
        host_req.sel <= 1'b0;
    endtask : hw
    task automatic rc(input logic [31:0] a, input logic [31:0] exp);
        @(posedge clk);
        host_req <= '{1'b1, 1'b0, a, 32'h0};
        @(posedge clk);
        host_req.sel <= 1'b0;
        @(negedge clk);
        d = host_rdata;
        chk(d, exp);
    endtask : rc
    function automatic int pp(int v);
        return ((TB + 4 * v) >> 2) & 32'h3fffff;
    endfunction : pp
    task automatic fill(int v);
        mt[vict] = v;
        mp[vict] = pp(v);
        mv[vict] = 1;
        vict = (vict == 7) ? bptr : vict + 1;
    endtask : fill
    task automatic look(input int v, input logic b);
        int h, n, acks, m;
        logic [23:0] va;
        h = -1;
        acks = 0;
        va = {v[13:0], 10'($urandom)};
        for (int i = 0; i < 8; i++) if (mv[i] != 0 && mt[i] == v) h = i;
        m = (h < 0);
        @(posedge clk);
        lk <= '{1'b1, 1'($urandom), va};
        bad <= b;
        slow <= 1'($urandom);
        for (n = 0; n < 300 && lk_done !== 1'b1; n++) begin
            @(negedge clk);
            acks += int'(wk_ack === 1'b1);
            if (bad === 1'b1 && fault_irq === 1'b1) begin
                rc(ADDR_CAUSE, 32'(FC_TABLE));
                rc(ADDR_FAULT_H, {24'h0, va[23:16]});
                rc(ADDR_FAULT_L, {16'h0, va[15:0]});
                bad <= 1'b0;
                hw(ADDR_ACK, 32'h0);
            end
        end
        if (n == 300) begin
            err_count++;
            complete_run();
        end
        @(posedge clk);
        lk.req <= 1'b0;
        if (m != 0) begin
            h = vict;
            fill(v);
        end
        chk(lk_paddr, {mp[h][21:0], va[9:0]});
        chk(32'(acks), m != 0 ? 32'(1 + int'(b)) : 32'h0);
    endtask : look
    initial begin
        void'($urandom(32'h8a51));
        srst = 1'b1;
        host_req = '0;
        lk = '0;
        {dsp_io_we, dsp_io_addr, dsp_io_wdata, slow, bad} = '0;
        {err_count, num_checks, vict, bptr} = '0;
        foreach (mv[i]) mv[i] = 0;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        rc(ADDR_CONTROL, 32'h0);
        hw(ADDR_CONTROL, 32'h1);
        hw(ADDR_TB_H, 32'h0012);
        hw(ADDR_TB_L, 32'h34ff);
        rc(ADDR_TB_L, 32'h3480);
        hw(ADDR_LOCK, 32'h400);
        hw(ADDR_TAG_H, 32'h3000);
        hw(ADDR_TAG_L, 32'h1);
        hw(ADDR_XL_H, 32'haaaa);
        hw(ADDR_XL_L, 32'h9403);
        hw(ADDR_ACCESS, 32'h1);
        hw(ADDR_ACCESS, 32'h2);
        rc(ADDR_RB_TAG_H, 32'h3000);
        rc(ADDR_RB_XL_L, 32'h9403);
        {mt[0], mp[0], mv[0], vict, bptr} = {32'h3000, 32'h2aaaa5, 32'h1, 32'h1, 32'h1};
        hw(ADDR_LOCK, 32'h410);
        hw(ADDR_CONTROL, 32'h7);
        hw(ADDR_LOCK, 32'h0);
        rc(ADDR_LOCK, 32'h410);
        $display("test registers done");
        look(32'h3000, 1'b0);
        for (int i = 0; i < 14; i++) look(int'($urandom % 10), 1'b0);
        look(int'($urandom % 10) + 64, 1'b1);
        $display("test walks done");
        t = 14'h2000 + int'($urandom % 64);
        slow <= 1'b1;
        @(posedge clk);
        {dsp_io_we, dsp_io_addr, dsp_io_wdata} <= {1'b1, DSP_IO_PRELOAD, 18'($urandom), t[13:0]};
        @(posedge clk);
        dsp_io_we <= 1'b0;
        rc(ADDR_WALK_ST, 32'h1);
        for (int n = 0; n < 40 && wk_ack !== 1'b1; n++) @(negedge clk);
        rc(ADDR_WALK_ST, 32'h0);
        chk(d, 32'h0);
        rc(ADDR_PRELOAD, 32'(t[13:0]));
        fill(t);
        look(t, 1'b0);
        $display("test preload done");
        t = mt[vict];
        hw(ADDR_FLUSH_ONE, 32'h1);
        mv[vict] = 0;
        look(t, 1'b0);
        hw(ADDR_FLUSH_ALL, 32'h1);
        for (int i = 1; i < 8; i++) mv[i] = 0;
        look(32'h3000, 1'b0);
        look(t, 1'b0);
        $display("test flush done");
        complete_run();
    end
endmodule : dmw_walk_ctrl_tb
